// [design/bst_tap_dev.sv]
// Purpose: Device end of the boundary-scan port with its scan registers.
// Assumes: Link pins sampled by clk_sys; link clock well below clk_sys.
// Notes:   Capture and shift on link rise, update and TDO on link fall.
`timescale 1ns/1ns
`default_nettype none
`include "bst_consts.svh"
module bst_tap_dev
    import bst_pkg::*;
#(
    parameter int                     BSR_LEN    = `BST_BSR_LEN_DEF,
    parameter logic [3:0]             ID_VERSION = 4'h3,     // Arbitrary value
    parameter logic [15:0]            ID_PART    = 16'h5A5A, // Arbitrary value
    parameter logic [10:0]            ID_MAKER   = 11'h2B1,  // Arbitrary value
    parameter logic [24:0]            USER_FIXED = 25'h0ABCDE // Arbitrary value
)(
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    bst_if.dev                        link,
    input  wire logic [BSR_LEN-1:0]   pin_in,
    input  wire logic [`BST_USER_W-1:0] user_sig,
    output logic [BSR_LEN-1:0]        pin_out,
    output logic                      pin_drive,
    output logic                      cfg_active,
    output logic                      cfg_bit,
    output logic                      cfg_bit_valid
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]             tck_s;
        logic [1:0]             tms_s;
        logic [1:0]             tdi_s;
        bst_tap_state_type      tap;
        logic [`BST_IR_W-1:0]   ir_sh;
        logic [`BST_IR_W-1:0]   ir;
        logic [`BST_WORD_W-1:0] wd_sh;
        logic                   byp;
        logic [BSR_LEN-1:0]     pin_s1;
        logic [BSR_LEN-1:0]     pin_s2;
        logic [BSR_LEN-1:0]     bsr_sh;
        logic [BSR_LEN-1:0]     bsr_up;
        logic                   tdo;
        logic                   tdo_oe;
        logic                   cfg_on;
        logic                   cfg_bit;
        logic                   cfg_vld;
    } bst_dev_state_type;

    localparam bst_dev_state_type DEV_RST = '{
        tap: BST_TLR, ir: `BST_OP_IDCODE, default: '0};

    // Identification word, LSB fixed at one
    localparam logic [`BST_WORD_W-1:0] ID_WORD =
        {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    bst_dev_state_type q;
    bst_dev_state_type d;
    logic              rise;
    logic              fall;
    logic              tms_v;
    logic              tdi_v;
    bst_path_type      path;

    // ------------------------------------------------------------
    // Controller next state
    // ------------------------------------------------------------
    function automatic bst_tap_state_type tap_next(
        input bst_tap_state_type s,
        input logic              m
    );
        unique case (s)
            BST_TLR:      tap_next = m ? BST_TLR    : BST_RTI;
            BST_RTI:      tap_next = m ? BST_SEL_DR : BST_RTI;
            BST_SEL_DR:   tap_next = m ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR:   tap_next = m ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR:    tap_next = m ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR:   tap_next = m ? BST_UPD_DR : BST_PAUSE_DR;
            BST_PAUSE_DR: tap_next = m ? BST_EX2_DR : BST_PAUSE_DR;
            BST_EX2_DR:   tap_next = m ? BST_UPD_DR : BST_SH_DR;
            BST_UPD_DR:   tap_next = m ? BST_SEL_DR : BST_RTI;
            BST_SEL_IR:   tap_next = m ? BST_TLR    : BST_CAP_IR;
            BST_CAP_IR:   tap_next = m ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR:    tap_next = m ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR:   tap_next = m ? BST_UPD_IR : BST_PAUSE_IR;
            BST_PAUSE_IR: tap_next = m ? BST_EX2_IR : BST_PAUSE_IR;
            BST_EX2_IR:   tap_next = m ? BST_UPD_IR : BST_SH_IR;
            BST_UPD_IR:   tap_next = m ? BST_SEL_DR : BST_RTI;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    function automatic bst_path_type path_of(
        input logic [`BST_IR_W-1:0] op,
        input logic                 cfg
    );
        case (op)
            `BST_OP_IDCODE:   path_of = BST_PATH_ID;
            `BST_OP_USERCODE: path_of = BST_PATH_USER;
            `BST_OP_EXTEST,
            `BST_OP_SAMPLE:   path_of = cfg ? BST_PATH_BYP : BST_PATH_BSR;
            `BST_OP_CFG_LOAD: path_of = BST_PATH_CFG;
            default:          path_of = BST_PATH_BYP;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state of the whole record
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // Two-flop sync of link pins, third stage for edges
        d.tck_s = {q.tck_s[1], q.tck_s[0], link.tck};
        d.tms_s = {q.tms_s[0], link.tms};
        d.tdi_s = {q.tdi_s[0], link.tdi};
        d.pin_s1 = pin_in;
        d.pin_s2 = q.pin_s1;
        d.cfg_vld = 1'b0;
        rise = q.tck_s[1] && !q.tck_s[2];
        fall = !q.tck_s[1] && q.tck_s[2];
        tms_v = q.tms_s[1];
        tdi_v = q.tdi_s[1];
        path = path_of(q.ir, q.cfg_on);

        // Rising link edge: move controller, capture and shift
        if (rise) begin
            d.tap = tap_next(q.tap, tms_v);
            if (q.tap == BST_TLR) begin
                d.ir = `BST_OP_IDCODE;
            end
            if (q.tap == BST_CAP_IR) begin
                d.ir_sh = `BST_IR_CAPTURE;
            end
            if (q.tap == BST_SH_IR) begin
                d.ir_sh = {tdi_v, q.ir_sh[`BST_IR_W-1:1]};
            end
            if (q.tap == BST_CAP_DR) begin
                unique case (path)
                    BST_PATH_BYP,
                    BST_PATH_CFG:  d.byp = 1'b0;
                    BST_PATH_ID:   d.wd_sh = ID_WORD;
                    BST_PATH_USER: d.wd_sh = {USER_FIXED, user_sig};
                    BST_PATH_BSR:  d.bsr_sh = q.pin_s2;
                endcase
            end
            if (q.tap == BST_SH_DR) begin
                unique case (path)
                    BST_PATH_BYP:  d.byp = tdi_v;
                    BST_PATH_CFG: begin
                        d.byp = tdi_v;
                        d.cfg_bit = tdi_v;
                        d.cfg_vld = 1'b1;
                    end
                    BST_PATH_ID,
                    BST_PATH_USER: d.wd_sh = {tdi_v, q.wd_sh[`BST_WORD_W-1:1]};
                    BST_PATH_BSR:  d.bsr_sh = {tdi_v, q.bsr_sh[BSR_LEN-1:1]};
                endcase
            end
        end

        // Falling link edge: update registers and serial output
        if (fall) begin
            if (q.tap == BST_UPD_IR) begin
                d.ir = q.ir_sh;
                if (q.ir_sh == `BST_OP_CFG_LOAD) begin
                    d.cfg_on = 1'b1;
                end else if (q.ir_sh == `BST_OP_CFG_END) begin
                    d.cfg_on = 1'b0;
                end
            end
            if ((q.tap == BST_UPD_DR) && (path == BST_PATH_BSR)) begin
                d.bsr_up = q.bsr_sh;
            end
            // Drive only in the two shift states
            d.tdo_oe = (q.tap == BST_SH_DR) || (q.tap == BST_SH_IR);
            if (q.tap == BST_SH_IR) begin
                d.tdo = q.ir_sh[0];
            end else begin
                unique case (path)
                    BST_PATH_BYP,
                    BST_PATH_CFG:  d.tdo = q.byp;
                    BST_PATH_ID,
                    BST_PATH_USER: d.tdo = q.wd_sh[0];
                    BST_PATH_BSR:  d.tdo = q.bsr_sh[0];
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.tdo_o    = q.tdo;
    assign link.tdo_oe   = q.tdo_oe;
    assign pin_out       = q.bsr_up;
    // Pattern reaches pins only under external test, not during config
    assign pin_drive     = (q.ir == `BST_OP_EXTEST) && !q.cfg_on;
    assign cfg_active    = q.cfg_on;
    assign cfg_bit       = q.cfg_bit;
    assign cfg_bit_valid = q.cfg_vld;

endmodule
`default_nettype wire

// [design/bst_tap_host.sv]
// Purpose: Scan controller end; walks the link for reset, IR and DR.
// Assumes: Link clock made here by dividing clk_sys.
// Notes:   DR bits are fed and returned one per link clock.
`timescale 1ns/1ns
`default_nettype none
`include "bst_consts.svh"
module bst_tap_host
    import bst_pkg::*;
#(
    parameter int DIV   = `BST_TCK_DIV,
    parameter int LEN_W = `BST_LEN_W
)(
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    bst_if.host                        link,
    input  wire logic                  cmd_valid,
    output logic                       cmd_ready,
    input  wire logic [1:0]            cmd_kind,
    input  wire logic [`BST_IR_W-1:0]  cmd_ir,
    input  wire logic [LEN_W-1:0]      cmd_len,
    input  wire logic                  bit_in_valid,
    input  wire logic                  bit_in,
    output logic                       bit_in_ready,
    output logic                       bit_out_valid,
    output logic                       bit_out,
    output logic                       cmd_refused,
    output logic                       cfg_mode,
    output logic                       busy
);

    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] CNT_HALF = CW'(DIV / 2);
    localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [1:0]           tdo_s;
        bst_phase_type        phase;
        bst_cmd_type          kind;
        logic [CW-1:0]        cnt;
        logic [5:0]           seq;
        logic [2:0]           seq_n;
        logic [LEN_W-1:0]     left;
        logic [`BST_IR_W-1:0] ir_sh;
        logic                 tck;
        logic                 tms;
        logic                 tdi;
        logic                 bout;
        logic                 bout_v;
        logic                 refused;
        logic                 cfg;
    } bst_host_state_type;

    localparam bst_host_state_type HOST_RST = '{
        phase: BST_PH_IDLE, kind: BST_CMD_RESET, tms: 1'b1, default: '0};

    bst_host_state_type q;
    bst_host_state_type d;
    logic               stall;
    logic               start;
    logic               blocked;

    // ------------------------------------------------------------
    // Command acceptance and link stepping
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.tdo_s = {q.tdo_s[0], link.tdo};
        d.bout_v = 1'b0;
        d.refused = 1'b0;
        start = cmd_valid && (q.phase == BST_PH_IDLE);
        // Pin scan refused while configuration mode is on
        blocked = (cmd_kind == 2'b11)
            || ((cmd_kind == BST_CMD_DR) && (cmd_len == '0))
            || ((cmd_kind == BST_CMD_IR) && q.cfg
                && ((cmd_ir == `BST_OP_EXTEST) || (cmd_ir == `BST_OP_SAMPLE)));
        stall = (q.phase == BST_PH_SHIFT) && (q.kind == BST_CMD_DR) && !bit_in_valid;
        if (start && blocked) begin
            d.refused = 1'b1;
        end else if (start) begin
            d.kind = bst_cmd_type'(cmd_kind);
            d.phase = BST_PH_PRE;
            d.cnt = '0;
            unique case (bst_cmd_type'(cmd_kind))
                BST_CMD_RESET: begin
                    d.seq = `BST_SEQ_RESET;
                    d.seq_n = `BST_SEQ_RESET_N;
                end
                BST_CMD_IR: begin
                    d.seq = `BST_SEQ_IR;
                    d.seq_n = `BST_SEQ_IR_N;
                    d.ir_sh = cmd_ir;
                    d.left = LEN_W'(`BST_IR_W);
                    if (cmd_ir == `BST_OP_CFG_LOAD) begin
                        d.cfg = 1'b1;
                    end else if (cmd_ir == `BST_OP_CFG_END) begin
                        d.cfg = 1'b0;
                    end
                end
                BST_CMD_DR: begin
                    d.seq = `BST_SEQ_DR;
                    d.seq_n = `BST_SEQ_DR_N;
                    d.left = cmd_len;
                end
            endcase
        end else if (q.phase != BST_PH_IDLE) begin
            if (q.cnt == '0) begin
                // Falling edge: present mode and data bits
                if ((q.phase != BST_PH_SHIFT) && (q.seq_n == '0)) begin
                    // Last link clock had its full high time: drop it, go idle
                    d.tck = 1'b0;
                    d.phase = BST_PH_IDLE;
                end else if (!stall) begin
                    d.tck = 1'b0;
                    d.cnt = q.cnt + 1'b1;
                    d.tdi = 1'b0;
                    if (q.phase == BST_PH_SHIFT) begin
                        d.tms = (q.left == LEN_W'(1));
                        d.tdi = (q.kind == BST_CMD_IR) ? q.ir_sh[0] : bit_in;
                    end else begin
                        d.tms = q.seq[0];
                    end
                end
            end else if (q.cnt == CNT_LAST) begin
                // End of one link clock: sample and advance
                d.cnt = '0;
                if (q.phase == BST_PH_SHIFT) begin
                    d.bout = q.tdo_s[1];
                    d.bout_v = 1'b1;
                    d.ir_sh = q.ir_sh >> 1;
                    d.left = q.left - 1'b1;
                    if (q.left == LEN_W'(1)) begin
                        d.phase = BST_PH_POST;
                        d.seq = `BST_SEQ_POST;
                        d.seq_n = `BST_SEQ_POST_N;
                    end
                end else begin
                    d.seq = q.seq >> 1;
                    d.seq_n = q.seq_n - 1'b1;
                    // Ending walks go idle at the next falling edge; IR and DR pre walks enter shift here
                    if ((q.seq_n == 3'h1) && (q.phase == BST_PH_PRE)
                        && (q.kind != BST_CMD_RESET)) begin
                        d.phase = BST_PH_SHIFT;
                    end
                end
            end else begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt == CNT_HALF) begin
                    d.tck = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= HOST_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign link.tck_o    = q.tck;
    assign link.tms_o    = q.tms;
    assign link.tdi_o    = q.tdi;
    assign link.host_oe  = 1'b1;
    assign cmd_ready     = (q.phase == BST_PH_IDLE);
    assign bit_in_ready  = (q.phase == BST_PH_SHIFT) && (q.kind == BST_CMD_DR)
                           && (q.cnt == '0);
    assign bit_out_valid = q.bout_v;
    assign bit_out       = q.bout;
    assign cmd_refused   = q.refused;
    assign cfg_mode      = q.cfg;
    assign busy          = (q.phase != BST_PH_IDLE);

endmodule
`default_nettype wire

// [shared/bst_consts.svh]
// Purpose: Shared constants of the boundary-scan port, both ends.
// Assumes: Included by bare name from design modules.
// Notes:   Opcodes are ten bits; unlisted opcodes select bypass.
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// ----------------------------------------------------------------
// Instruction opcodes
// ----------------------------------------------------------------
`define BST_IR_W           10
`define BST_OP_EXTEST      10'h000
`define BST_OP_SAMPLE      10'h055
`define BST_OP_CFG_LOAD    10'h002
`define BST_OP_CFG_END     10'h003
`define BST_OP_IDCODE      10'h006
`define BST_OP_USERCODE    10'h007
`define BST_OP_BYPASS      10'h3FF
`define BST_IR_CAPTURE     10'h001

// ----------------------------------------------------------------
// Register sizes
// ----------------------------------------------------------------
`define BST_BSR_LEN_DEF    624
`define BST_WORD_W         32
`define BST_USER_W         7
`define BST_LEN_W          11

// ----------------------------------------------------------------
// Link timing and TMS walks (sent LSB first)
// ----------------------------------------------------------------
`define BST_CLK_PERIOD_NS  50
`define BST_TCK_PERIOD_NS  400
`define BST_TCK_DIV        (`BST_TCK_PERIOD_NS / `BST_CLK_PERIOD_NS)
`define BST_SEQ_RESET      6'h1F
`define BST_SEQ_RESET_N    3'h6
`define BST_SEQ_IR         6'h03
`define BST_SEQ_IR_N       3'h4
`define BST_SEQ_DR         6'h01
`define BST_SEQ_DR_N       3'h3
`define BST_SEQ_POST       6'h01
`define BST_SEQ_POST_N     3'h2

`endif

// [shared/bst_if.sv]
// Purpose: Four-wire test link between controller and device.
// Assumes: Host drives clock, mode and data in while its enable is up.
// Notes:   Undriven lines resolve high, as weak pull-ups would.
`timescale 1ns/1ns
`default_nettype none
interface bst_if;

    logic      tck_o;
    logic      tms_o;
    logic      tdi_o;
    logic      host_oe;
    logic      tdo_o;
    logic      tdo_oe;
    wire logic tck;
    wire logic tms;
    wire logic tdi;
    wire logic tdo;

    // Line levels with pull-ups on undriven lines
    assign tck = host_oe ? tck_o : 1'b1;
    assign tms = host_oe ? tms_o : 1'b1;
    assign tdi = host_oe ? tdi_o : 1'b1;
    assign tdo = tdo_oe ? tdo_o : 1'b1;

    modport dev  (input tck, tms, tdi, output tdo_o, tdo_oe);
    modport host (output tck_o, tms_o, tdi_o, host_oe, input tdo);

endinterface
`default_nettype wire

// [shared/bst_pkg.sv]
// Purpose: Types shared by both ends of the boundary-scan port.
// Assumes: Nothing beyond the constants header.
// Notes:   Controller codes are the usual sixteen-state set.
package bst_pkg;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BST_TLR      = 4'b1111,
        BST_RTI      = 4'b1100,
        BST_SEL_DR   = 4'b0111,
        BST_CAP_DR   = 4'b0110,
        BST_SH_DR    = 4'b0010,
        BST_EX1_DR   = 4'b0001,
        BST_PAUSE_DR = 4'b0011,
        BST_EX2_DR   = 4'b0000,
        BST_UPD_DR   = 4'b0101,
        BST_SEL_IR   = 4'b0100,
        BST_CAP_IR   = 4'b1110,
        BST_SH_IR    = 4'b1010,
        BST_EX1_IR   = 4'b1001,
        BST_PAUSE_IR = 4'b1011,
        BST_EX2_IR   = 4'b1000,
        BST_UPD_IR   = 4'b1101
    } bst_tap_state_type;

    // ------------------------------------------------------------
    // Data register selection
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BST_PATH_BYP  = 3'b000,
        BST_PATH_ID   = 3'b001,
        BST_PATH_USER = 3'b010,
        BST_PATH_BSR  = 3'b011,
        BST_PATH_CFG  = 3'b100
    } bst_path_type;

    // ------------------------------------------------------------
    // Host commands and phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BST_CMD_RESET = 2'b00,
        BST_CMD_IR    = 2'b01,
        BST_CMD_DR    = 2'b10
    } bst_cmd_type;

    typedef enum logic [1:0] {
        BST_PH_IDLE  = 2'b00,
        BST_PH_PRE   = 2'b01,
        BST_PH_SHIFT = 2'b10,
        BST_PH_POST  = 2'b11
    } bst_phase_type;

endpackage

// [verif/bst_link_asserts.sv]
// Purpose: Wire checks on the test link.
// Assumes: Host divides clk_sys for the link clock.
// Notes:   Sees interface signals only.
`timescale 1ns/1ns
`default_nettype none
module bst_link_asserts (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_o,
    input wire logic tdo_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [2:0] ones_q;
    logic       tck_q;
    // Run of mode-high link rises
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tck_q  <= 1'b0;
            ones_q <= 3'h0;
        end else begin
            tck_q <= tck;
            if (tck && !tck_q)
                ones_q <= !tms ? 3'h0 : ones_q + {2'h0, ones_q != 3'h7};
        end
    end
    // ----
    // Checks
    // ----
    a_tck_high_len: assert property ($rose(tck) |-> tck[*4] ##1 !tck)
        else $error("link clock high time");
    a_tck_low_len: assert property ($fell(tck) |-> !tck[*4])
        else $error("link clock low time");
    a_tms_on_fall: assert property ($changed(tms) |-> !tck)
        else $error("mode moved while clock high");
    a_tdi_on_fall: assert property ($changed(tdi) |-> !tck)
        else $error("data in moved while clock high");
    a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck)
        else $error("output enable moved while clock high");
    a_tdo_on_fall: assert property (tdo_oe && $changed(tdo_o) |-> !tck)
        else $error("data out moved while clock high");
    a_tdo_pulled: assert property (!tdo_oe |-> tdo)
        else $error("idle data out not high");
    a_reset_quiet: assert property (ones_q >= 3'h5 |-> !tdo_oe)
        else $error("data out driven in reset state");
    cover property ($rose(tdo_oe));
    cover property (ones_q == 3'h5);
    cover property ($fell(tdo_oe) ##[1:40] $rose(tdo_oe));
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: Bench for both ends of the test link.
// Assumes: Eight boundary cells.
// Notes:   Expected words from bench functions.
`timescale 1ns/1ns
`default_nettype none
`include "bst_consts.svh"
module tb_top;
    localparam int          BL   = 8;
    localparam logic [3:0]  VER  = 4'h9;        // Arbitrary value
    localparam logic [15:0] PART = 16'hC3D2;    // Arbitrary value
    localparam logic [10:0] MAKR = 11'h4E5;     // Arbitrary value
    localparam logic [24:0] UFIX = 25'h1234567; // Arbitrary value
    localparam logic [31:0] IDW  = {VER, PART, MAKR, 1'b1};
    logic clk_sys, resetn, cmd_valid, cmd_ready, bit_in_valid, bit_in, bit_in_ready, ref_q;
    logic bit_out_valid, bit_out, cmd_refused, cfg_mode, busy, pin_drive, cfg_active;
    logic cfg_bit, cfg_bit_valid;
    logic [1:0]    cmd_kind;
    logic [1:0]    kinds [4] = '{2'h1, 2'h1, 2'h3, 2'h2};
    logic [9:0]    cmd_ir, op;
    logic [10:0]   cmd_len;
    logic [6:0]    user_sig;
    logic [BL-1:0] pin_in, pin_out;
    logic [63:0]   got, d, cfgw;
    int            n_mismatch = 0, checks = 0, cyc = 0, ncfg = 0, nb, len;
    bst_if link_if ();
    bst_tap_host bst_tap_host_inst (.clk_sys(clk_sys), .resetn(resetn), .link(link_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_ir(cmd_ir),
        .cmd_len(cmd_len), .bit_in_valid(bit_in_valid), .bit_in(bit_in),
        .bit_in_ready(bit_in_ready), .bit_out_valid(bit_out_valid), .bit_out(bit_out),
        .cmd_refused(cmd_refused), .cfg_mode(cfg_mode), .busy(busy));
    bst_tap_dev #(.BSR_LEN(BL), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKR),
        .USER_FIXED(UFIX)) bst_tap_dev_inst (.clk_sys(clk_sys), .resetn(resetn),
        .link(link_if), .pin_in(pin_in), .user_sig(user_sig), .pin_out(pin_out),
        .pin_drive(pin_drive), .cfg_active(cfg_active), .cfg_bit(cfg_bit),
        .cfg_bit_valid(cfg_bit_valid));
    bst_link_asserts bst_link_asserts_inst (.clk_sys(clk_sys), .resetn(resetn),
        .tck(link_if.tck), .tms(link_if.tms), .tdi(link_if.tdi), .tdo(link_if.tdo),
        .tdo_o(link_if.tdo_o), .tdo_oe(link_if.tdo_oe));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Cycle limit and configuration stream capture
    always @(posedge clk_sys) begin
        cyc++;
        if (cfg_bit_valid && ncfg < 64) begin
            cfgw[ncfg] = cfg_bit;
            ncfg++;
        end
        if (cyc == 30000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One host command; gathers returned bits
    task automatic run(logic [1:0] k, logic [9:0] ir, int n, logic [63:0] din);
        int i = 0;
        int t = 0;
        {cmd_kind, cmd_ir, cmd_len, bit_in} = {k, ir, n[10:0], din[0]};
        got = '0;
        nb = 0;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        ref_q = cmd_refused;
        while (busy && t++ < 3000) begin
            if (bit_out_valid)
                got[nb++] = bit_out;
            i += int'(bit_in_ready);
            @(negedge clk_sys);
            bit_in = din[i[5:0]];
        end
        if (busy) begin
            n_mismatch++;
            final_report();
        end
    endtask
    function automatic logic [63:0] byp(logic [63:0] v, int n);
        return {v[62:0], 1'b0} & ((64'h1 << n) - 64'h1);
    endfunction
    initial begin
        void'($urandom(32'h9DB3));
        {resetn, cmd_valid, cmd_kind, cmd_ir, cmd_len, bit_in} = '0;
        bit_in_valid = 1'b1;
        pin_in = BL'($urandom);
        user_sig = 7'($urandom);
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        run(2'h0, 10'h0, 0, 64'h0);
        run(2'h2, 10'h0, 32, 64'h0);
        chk("idcode", got, 64'(IDW));
        for (int j = 0; j < 6; j++) begin
            op = (j < 2) ? `BST_OP_BYPASS : 10'h100 + 10'($urandom % 255);
            d = {$urandom, $urandom};
            len = (j == 0) ? 1 : 1 + $urandom % 40;
            run(2'h1, op, 0, 64'h0);
            chk("ir capture", got, 64'(`BST_IR_CAPTURE));
            chk("ir length", 64'(nb), 64'hA);
            run(2'h2, 10'h0, len, d);
            chk("bypass", got, byp(d, len));
        end
        run(2'h1, `BST_OP_USERCODE, 0, 64'h0);
        run(2'h2, 10'h0, 32, 64'h0);
        chk("usercode", got, 64'({UFIX, user_sig}));
        for (int j = 0; j < 2; j++) begin
            pin_in = BL'($urandom);
            d = 64'($urandom);
            run(2'h1, j ? `BST_OP_EXTEST : `BST_OP_SAMPLE, 0, 64'h0);
            run(2'h2, 10'h0, BL, d);
            chk("pin capture", got, 64'(pin_in));
            chk("pin update", 64'(pin_out), 64'(d[BL-1:0]));
            chk("pin drive", 64'(pin_drive), 64'(j));
        end
        run(2'h0, 10'h0, 0, 64'h0);
        run(2'h2, 10'h0, 32, 64'h0);
        chk("reset idcode", got, 64'(IDW));
        d = {$urandom, $urandom};
        run(2'h1, `BST_OP_CFG_LOAD, 0, 64'h0);
        chk("cfg on", 64'({cfg_mode, cfg_active, pin_drive}), 64'h6);
        run(2'h2, 10'h0, 40, d);
        chk("cfg bits", 64'(cfgw[39:0]) | 64'(ncfg) << 40, 64'(d[39:0]) | 64'h28 << 40);
        for (int j = 0; j < 4; j++) begin
            run(kinds[j], j == 1 ? `BST_OP_SAMPLE : `BST_OP_EXTEST, 0, 64'h0);
            chk("refused", 64'({ref_q, pin_drive}), 64'h2);
        end
        run(2'h1, `BST_OP_CFG_END, 0, 64'h0);
        chk("cfg off", 64'({cfg_mode, cfg_active}), 64'h0);
        run(2'h1, `BST_OP_EXTEST, 0, 64'h0);
        chk("scan after cfg", 64'({ref_q, pin_drive}), 64'h1);
        final_report();
    end
endmodule
`default_nettype wire
